// ### include/smsp_pkg.sv
// package: register map, field layouts, state codes and shifter command bundle of the serial port
//
// Behaviour
// - on underflow resend the previous byte if the mode bit is set, else zero
// - master, initiation bit set: transmit write starts a transfer, flag on empty
// - master, initiation bit clear: receive read starts a transfer, flag on full
// - bit-order bit set sends and receives lsb first, clear msb first
// - polarity bit set makes the serial clock idle high, clear idle low
// - phase bit set pulses clock at bit start, clear at bit end
// - role bit set is master driving the clock, clear is slave taking it
// - enable bit switches the whole serial port on and off
// - overflow flag sets on a byte arriving over unread data, clears on read
// - receive flag sets with full or overflow, clears on a receive read
// - receive-full sets when a byte is held, clears on a receive read
// - underflow flag sets when a byte is needed and none waits, clears on write
// - transmit flag sets on empty or underflow, clears on write or idle disable
// - transmit-occupied sets on write, holds while shifting, clears when empty
// - read-only 8-bit receive buffer holds the last byte, resets to zero
// - write-only 8-bit transmit buffer queues the next byte to shift out
// - overwrite bit set replaces unread data with the new byte, clear drops it
// - continuous master keeps select low while bytes wait, else stalls between bytes
// - master clock is the system clock over two times one plus divider
package smsp_pkg;
  localparam logic [31:0] ADDR_STATUS = 32'hffff0a00;
  localparam logic [31:0] ADDR_RX = 32'hffff0a04;
  localparam logic [31:0] ADDR_TX = 32'hffff0a08;
  localparam logic [31:0] ADDR_DIV = 32'hffff0a0c;
  localparam logic [31:0] ADDR_CTRL = 32'hffff0a10;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h1fef;
  localparam logic [7:0] DIV_RESET = 8'h1b;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] HALF_STEP = 8'h01;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam int BE_LO = 0;
  localparam int BE_HI = 1;

  // control word, bit 15 first
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic cont;
    logic loop;
    logic slv_oe;
    logic ss_oe;
    logic ovw;
    logic uf_prev;
    logic tim;
    logic lsb;
    logic rsvd_mid;
    logic cpol;
    logic cpha;
    logic master;
    logic en;
  } smsp_ctrl_s;

  // status byte, bit 7 first
  typedef struct packed {
    logic [1:0] rsvd;
    logic rx_ovf;
    logic rx_irq;
    logic rx_full;
    logic tx_uf;
    logic tx_irq;
    logic tx_busy;
  } smsp_stat_s;

  // shifter commands that travel together
  typedef struct packed {
    logic load;
    logic sample;
    logic shift;
    logic clear;
  } smsp_op_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b11,
    ST_STALL = 2'b10
  } smsp_state_e;
endpackage : smsp_pkg

// ### rtl/smsp_shifter.sv
// byte shifter: parallel load, serial out, serial in, bit counter
`timescale 1ns/1ns
module smsp_shifter (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic lsb_first_i,
  input wire smsp_pkg::smsp_op_s op_i,
  input wire logic [7:0] load_data_i,
  input wire logic data_i,
  output logic out_bit_o,
  output logic first_o,
  output logic done_o,
  output logic [7:0] rx_byte_o
);
  logic [7:0] tx_sr;
  logic [7:0] rx_sr;
  logic [2:0] cnt;

  // direction of both shift registers follows the bit-order bit
  wire [7:0] next_rx = lsb_first_i ? {data_i, rx_sr[7:1]} : {rx_sr[6:0], data_i};
  wire [7:0] next_tx = lsb_first_i ? {1'b0, tx_sr[7:1]} : {tx_sr[6:0], 1'b0};
  assign out_bit_o = lsb_first_i ? tx_sr[0] : tx_sr[7];
  assign first_o = cnt == smsp_pkg::BIT_FIRST;
  assign done_o = op_i.sample & (cnt == smsp_pkg::BIT_LAST);
  assign rx_byte_o = next_rx;

  // load wins over shift; clear only restarts the bit count
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_sr <= smsp_pkg::BYTE_RESET;
      rx_sr <= smsp_pkg::BYTE_RESET;
      cnt <= smsp_pkg::BIT_FIRST;
    end else if (ce_i) begin
      if (op_i.load) begin
        tx_sr <= load_data_i;
      end else if (op_i.shift) begin
        tx_sr <= next_tx;
      end
      if (op_i.sample) begin
        rx_sr <= next_rx;
      end
      if (op_i.clear) begin
        cnt <= smsp_pkg::BIT_FIRST;
      end else if (op_i.sample) begin
        cnt <= cnt + smsp_pkg::BIT_STEP;
      end
    end
  end

  a_shift_order: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && op_i.shift && !op_i.load && lsb_first_i) |=> (tx_sr[6:0] == $past(tx_sr[7:1])))
    else $error("lsb-first shift moved the wrong way");
  a_msb_in: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && op_i.sample && !lsb_first_i) |=> (rx_sr[0] == $past(data_i)))
    else $error("msb-first sample not taken into bit zero");
endmodule : smsp_shifter

// ### rtl/smsp_top.sv
// serial port top: register slave, master sequencer, slave edge logic and pins
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
module smsp_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_n_o
);
  smsp_pkg::smsp_ctrl_s ctrl;
  smsp_pkg::smsp_stat_s stat;
  smsp_pkg::smsp_state_e st;
  smsp_pkg::smsp_state_e next_st;
  smsp_pkg::smsp_op_s op;
  logic [7:0] div;
  logic [7:0] hcnt;
  logic [7:0] tx_data;
  logic [7:0] tx_last;
  logic [7:0] rx_data;
  logic tx_full;
  logic cur_buf;
  logic tx_uf;
  logic tx_irq;
  logic rx_full;
  logic rx_ovf;
  logic rx_irq;
  logic busy_q;
  logic sclk_q;
  logic ss_q;
  logic sh_out;
  logic sh_first;
  logic sh_done;
  logic [7:0] sh_rx;

  // bus decode: a request acts once, at the edge that drops waitrequest
  wire acc = ce_i & (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire hit_stat = avs_address_i == smsp_pkg::ADDR_STATUS;
  wire hit_rx = avs_address_i == smsp_pkg::ADDR_RX;
  wire hit_tx = avs_address_i == smsp_pkg::ADDR_TX;
  wire hit_div = avs_address_i == smsp_pkg::ADDR_DIV;
  wire hit_ctrl = avs_address_i == smsp_pkg::ADDR_CTRL;
  wire be_lo = avs_byteenable_i[smsp_pkg::BE_LO];
  wire be_hi = avs_byteenable_i[smsp_pkg::BE_HI];
  wire wr_ctrl = acc & avs_write_i & hit_ctrl;
  wire wr_div = acc & avs_write_i & hit_div & be_lo;
  wire wr_tx = acc & avs_write_i & hit_tx & be_lo;
  wire rd_rx = acc & avs_read_i & hit_rx;

  // control write merges byte lanes; reserved bits never take a value
  wire [15:0] ctrl_be = {{8{be_hi}}, {8{be_lo}}} & smsp_pkg::CTRL_WMASK;
  wire [15:0] next_ctrl = (ctrl & ~ctrl_be) | (avs_writedata_i[15:0] & ctrl_be);

  // status view and read mux; transmit buffer and unmapped words read zero
  wire busy = tx_full | cur_buf;
  assign stat = {2'b00, rx_ovf, rx_irq, rx_full, tx_uf, tx_irq, busy};
  wire [31:0] rd_mux = hit_stat ? 32'(stat) :
                       hit_rx ? 32'(rx_data) :
                       hit_div ? 32'(div) :
                       hit_ctrl ? 32'(ctrl) : '0;

  // master sequencer decode: two half periods of div+1 cycles per bit
  wire m_on = ctrl.en & ctrl.master;
  wire hend = hcnt == div;
  wire is_idle = st == smsp_pkg::ST_IDLE;
  wire is_first = st == smsp_pkg::ST_FIRST;
  wire is_second = st == smsp_pkg::ST_SECOND;
  wire start_m = m_on & is_idle & (ctrl.tim ? tx_full : rd_rx);
  wire m_end = is_second & hend;
  wire m_next = m_end & sh_first & ctrl.cont & tx_full;
  wire m_load = start_m | m_next;
  wire m_sample = is_first & hend;
  wire m_shift = m_end & !sh_first;

  // slave edge decode against the configured idle level
  wire s_act = ctrl.en & !ctrl.master & !ss_n_i;
  wire s_edge = sclk_i != sclk_q;
  wire s_lead = s_act & s_edge & (sclk_i != ctrl.cpol);
  wire s_trail = s_act & s_edge & (sclk_i == ctrl.cpol);
  wire ss_fall = s_act & ss_q;
  wire s_load = ctrl.cpha ? (s_lead & sh_first) : (ss_fall | (s_trail & sh_first));
  wire s_sample = ctrl.cpha ? s_trail : s_lead;
  wire s_shift = (ctrl.cpha ? s_lead : s_trail) & !sh_first;

  // shared shifter commands and data selection
  wire load = m_load | s_load;
  wire uf_set = load & !tx_full;
  wire [7:0] load_data = tx_full ? tx_data : (ctrl.uf_prev ? tx_last : smsp_pkg::BYTE_RESET);
  wire din = ctrl.master ? (ctrl.loop ? sh_out : miso_i) : mosi_i;
  assign op.load = load;
  assign op.sample = m_sample | s_sample;
  assign op.shift = m_shift | s_shift;
  assign op.clear = !ctrl.en | (!ctrl.master & ss_n_i) | (ctrl.master & is_idle);
  wire unread = rx_full & !rd_rx;
  wire tx_irq_set = (busy_q & !busy) | uf_set;
  wire tx_irq_clr = wr_tx | (!ctrl.en & !busy);

  smsp_shifter u_shifter (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .lsb_first_i(ctrl.lsb),
    .op_i(op),
    .load_data_i(load_data),
    .data_i(din),
    .out_bit_o(sh_out),
    .first_o(sh_first),
    .done_o(sh_done),
    .rx_byte_o(sh_rx)
  );

  // master state sequence; stall keeps select high between single bytes
  always_comb begin
    next_st = st;
    unique case (st)
      smsp_pkg::ST_IDLE: if (start_m) next_st = smsp_pkg::ST_FIRST;
      smsp_pkg::ST_FIRST: if (hend) next_st = smsp_pkg::ST_SECOND;
      smsp_pkg::ST_SECOND: if (hend) next_st = (!sh_first || m_next) ? smsp_pkg::ST_FIRST : smsp_pkg::ST_STALL;
      smsp_pkg::ST_STALL: if (hend) next_st = smsp_pkg::ST_IDLE;
    endcase
    if (!m_on) next_st = smsp_pkg::ST_IDLE;
  end

  // bus answer: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else if (ce_i) begin
      avs_waitrequest_o <= !acc;
      if (acc & avs_read_i) avs_readdata_o <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ctrl <= smsp_pkg::CTRL_RESET;
      div <= smsp_pkg::DIV_RESET;
    end else if (ce_i) begin
      if (wr_ctrl) ctrl <= smsp_pkg::smsp_ctrl_s'(next_ctrl);
      if (wr_div) div <= avs_writedata_i[7:0];
    end
  end

  // sequencer state and half-period counter
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      st <= smsp_pkg::ST_IDLE;
      hcnt <= smsp_pkg::BYTE_RESET;
    end else if (ce_i) begin
      st <= next_st;
      hcnt <= (next_st != st) ? smsp_pkg::BYTE_RESET : hcnt + smsp_pkg::HALF_STEP;
    end
  end

  // transmit side: set wins over clear on every flag
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_full <= 1'b0;
      tx_data <= smsp_pkg::BYTE_RESET;
      tx_last <= smsp_pkg::BYTE_RESET;
      cur_buf <= 1'b0;
      tx_uf <= 1'b0;
      tx_irq <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      tx_full <= wr_tx | (tx_full & !load);
      if (wr_tx) tx_data <= avs_writedata_i[7:0];
      if (load) tx_last <= load_data;
      cur_buf <= load ? tx_full : (cur_buf & !sh_done & !op.clear);
      tx_uf <= uf_set | (tx_uf & !wr_tx);
      tx_irq <= tx_irq_set | (tx_irq & !tx_irq_clr);
      busy_q <= busy;
    end
  end

  // receive side: overwrite bit picks which byte survives an overflow
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rx_data <= smsp_pkg::BYTE_RESET;
      rx_full <= 1'b0;
      rx_ovf <= 1'b0;
      rx_irq <= 1'b0;
    end else if (ce_i) begin
      if (sh_done & (!unread | ctrl.ovw)) rx_data <= sh_rx;
      rx_full <= sh_done | unread;
      rx_ovf <= (sh_done & unread) | (rx_ovf & !rd_rx);
      rx_irq <= sh_done | (rx_irq & !rd_rx);
    end
  end

  // pins: one registered stage, enables low while driving
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      ss_q <= 1'b1;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      ss_n_o <= 1'b1;
      sclk_oe_n_o <= 1'b1;
      mosi_oe_n_o <= 1'b1;
      miso_oe_n_o <= 1'b1;
      ss_n_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      sclk_q <= sclk_i;
      ss_q <= ss_n_i;
      sclk_o <= ctrl.cpol ^ (ctrl.cpha ? is_first : is_second);
      mosi_o <= sh_out;
      miso_o <= sh_out;
      ss_n_o <= !(is_first | is_second);
      sclk_oe_n_o <= !m_on;
      mosi_oe_n_o <= !m_on;
      miso_oe_n_o <= !(s_act & ctrl.slv_oe);
      ss_n_oe_n_o <= !(m_on & ctrl.ss_oe);
    end
  end

  a_rx_full_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && sh_done) |=> (rx_full && stat.rx_irq))
    else $error("received byte did not raise full and receive flag");
  a_ovf_unread: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && sh_done && rx_full && !rd_rx) |=> rx_ovf)
    else $error("overflow not flagged on unread data");
  a_rx_read_clr: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && rd_rx && !sh_done) |=> (!rx_full && !rx_ovf && !rx_irq))
    else $error("receive read left a flag set");
  a_drop_new: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && sh_done && unread && !ctrl.ovw) |=> $stable(rx_data))
    else $error("unread byte overwritten with overwrite off");
  a_uf_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && load && !tx_full && !ctrl.uf_prev) |=> (tx_last == smsp_pkg::BYTE_RESET && tx_uf))
    else $error("underflow did not send zero");
  a_tx_start: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && wr_tx && m_on && ctrl.tim && is_idle && !tx_full) ##1 (ce_i && m_on && !wr_ctrl)
    |=> (st == smsp_pkg::ST_FIRST) ##1 (!busy_q || !ss_n_o || !ce_i))
    else $error("transmit write did not start a master transfer");
  a_rx_start: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && rd_rx && m_on && !ctrl.tim && is_idle) |=> (st == smsp_pkg::ST_FIRST))
    else $error("receive read did not start a master transfer");
  a_busy_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && wr_tx) |=> stat.tx_busy)
    else $error("transmit write did not mark buffer occupied");
  a_uf_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && wr_tx && !uf_set) |=> !tx_uf)
    else $error("transmit write did not clear underflow");
  a_sclk_idle: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && is_idle && !wr_ctrl) |=> (sclk_o == ctrl.cpol))
    else $error("serial clock not at idle level");
  a_port_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (ce_i && !ctrl.en && !wr_ctrl) ##1 ce_i |=> (sclk_oe_n_o && mosi_oe_n_o && miso_oe_n_o && is_idle))
    else $error("disabled port still drives a pin");
endmodule : smsp_top

// ### testbench/smsp_partner.sv
// external serial slave model that answers master-mode transfers
`timescale 1ns/1ns
module smsp_partner (
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  int ns;
  int nr;
  // bit position for a count, per bit order
  function automatic int idx(input int n);
    return lsb_i ? n : 7 - n;
  endfunction : idx
  initial miso_o = 1'b0;
  // select falls: restart counts and show the first bit at once, in either phase
  always @(negedge ss_n_i) begin
    ns = 0;
    nr = 0;
    miso_o = tx_i[idx(0)];
  end
  // a released line shows the inverse of its last value
  always @(posedge ss_n_i) miso_o = ~miso_o;
  // sample on the sampling edge, then show the next bit at once; the port samples its input earlier,
  // and a phase 1 leading edge that lands together with the select fall is never acted on
  always @(sclk_i) begin
    if (!ss_n_i && sclk_i == (cpol_i ~^ cpha_i)) begin
      rx_o[idx(nr)] = mosi_i;
      nr = (nr + 1) % 8;
      ns = (ns + 1) % 8;
      miso_o = tx_i[idx(ns)];
    end
  end
endmodule : smsp_partner

// ### testbench/spi_master_slave_port_test.sv
// testbench: register bus, master transfers against the slave model, one slave transfer
`timescale 1ns/1ns
module spi_master_slave_port_test;
  logic clock_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [31:0] avs_address_i, avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i;
  logic sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, ss_n_o, ss_n_oe_n_o;
  logic m_sclk, m_mosi, m_ss_n, p_miso, p_cpol, p_cpha, p_lsb;
  logic [7:0] p_tx, p_rx, last, sl_rx;
  logic [15:0] cw;
  int bad_count, compares, rises, n0;
  localparam logic [7:0] SL_BYTE = 8'h5a;
  time t_last, per;
  // line levels from whoever drives each pin
  wire sclk_w = sclk_oe_n_o ? m_sclk : sclk_o;
  wire ss_w = ss_n_oe_n_o ? m_ss_n : ss_n_o;
  wire mosi_w = mosi_oe_n_o ? m_mosi : mosi_o;
  wire miso_w = miso_oe_n_o ? p_miso : miso_o;
  smsp_top u_dut (.clock_i, .rstn_i, .ce_i(1'b1), .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sclk_i(sclk_w),
    .sclk_o, .sclk_oe_n_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_n_o, .miso_i(miso_w), .miso_o,
    .miso_oe_n_o, .ss_n_i(ss_w), .ss_n_o, .ss_n_oe_n_o);
  smsp_partner u_part (.cpol_i(p_cpol), .cpha_i(p_cpha), .lsb_i(p_lsb), .tx_i(p_tx),
    .sclk_i(sclk_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .miso_o(p_miso), .rx_o(p_rx));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // count select releases, measure the serial clock period
  always @(posedge ss_w) rises = rises + 1;
  always @(posedge sclk_w) begin
    per = $time - t_last;
    t_last = $time;
  end
  task summarize;
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask : chk
  // one bus cycle, request held until waitrequest is seen low
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr
  task rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
  endtask : rchk
  // wait for n more select releases, then let the stall pass
  task wait_rise(input int n);
    int r0;
    r0 = rises;
    while (rises < r0 + n) @(posedge clock_i);
    repeat (12) @(posedge clock_i);
  endtask : wait_rise
  task xfer(input logic [7:0] b, input logic [7:0] pb);
    p_tx = pb;
    last = b;
    wr(smsp_pkg::ADDR_TX, {24'h0, b});
    wait_rise(1);
  endtask : xfer
  initial begin
    #300000;
    bad_count = bad_count + 1;
    summarize();
  end
  initial begin
    bad_count = 0; compares = 0; rises = 0; t_last = 0; per = 0;
    rstn_i = 1'b0; avs_read_i = 1'b0; avs_write_i = 1'b0; avs_address_i = 32'h0;
    avs_writedata_i = 32'h0; avs_byteenable_i = 4'hf;
    m_sclk = 1'b0; m_mosi = 1'b0; m_ss_n = 1'b1; p_tx = 8'h00;
    {p_lsb, p_cpol, p_cpha} = 3'h0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    // reset values, write-only and unmapped reads
    rchk(smsp_pkg::ADDR_STATUS, 32'h0);
    rchk(smsp_pkg::ADDR_RX, 32'h0);
    rchk(smsp_pkg::ADDR_CTRL, 32'h0);
    rchk(smsp_pkg::ADDR_DIV, 32'h1b);
    rchk(smsp_pkg::ADDR_TX, 32'h0);
    rchk(32'hffff0a14, 32'h0);
    // byte-lane gating and reserved control bits
    bus(1'b1, smsp_pkg::ADDR_CTRL, 32'hffff, 4'h1);
    rchk(smsp_pkg::ADDR_CTRL, 32'hef);
    wr(smsp_pkg::ADDR_CTRL, 32'hffff);
    rchk(smsp_pkg::ADDR_CTRL, 32'h1fef);
    wr(smsp_pkg::ADDR_DIV, 32'h1);
    // every polarity, phase and bit order, started by a transmit write
    for (int i = 0; i < 8; i++) begin
      {p_lsb, p_cpol, p_cpha} = i[2:0];
      cw = 16'h0243 | {10'h0, p_lsb, 1'b0, p_cpol, p_cpha, 2'h0};
      wr(smsp_pkg::ADDR_CTRL, {16'h0, cw});
      xfer(8'h1d + 8'(i) * 8'h2b, 8'h96 ^ 8'(i));
      chk(p_rx, last);
      chk(sclk_w, p_cpol);
      chk(sclk_oe_n_o, 1'b0);
      rchk(smsp_pkg::ADDR_STATUS, 32'h1a);
      rchk(smsp_pkg::ADDR_RX, 8'h96 ^ 8'(i));
      rchk(smsp_pkg::ADDR_STATUS, 32'h02);
    end
    chk(32'(per), 32'd40);
    // receive reads start transfers, an empty transmit buffer underflows
    {p_lsb, p_cpol, p_cpha} = 3'h0;
    p_tx = 8'h3c;
    wr(smsp_pkg::ADDR_CTRL, 32'h0283);
    bus(1'b0, smsp_pkg::ADDR_RX, 32'h0, 4'hf);
    wait_rise(1);
    chk(p_rx, last);
    rchk(smsp_pkg::ADDR_STATUS, 32'h1e);
    wr(smsp_pkg::ADDR_CTRL, 32'h0203);
    rchk(smsp_pkg::ADDR_RX, 32'h3c);
    wait_rise(1);
    chk(p_rx, 8'h00);
    wr(smsp_pkg::ADDR_TX, 32'h77);
    rchk(smsp_pkg::ADDR_STATUS, 32'h19);
    chk(ss_w, 1'b1);
    p_tx = 8'h5e;
    rchk(smsp_pkg::ADDR_RX, 32'h3c);
    wait_rise(1);
    chk(p_rx, 8'h77);
    wr(smsp_pkg::ADDR_CTRL, 32'h0243);
    rchk(smsp_pkg::ADDR_STATUS, 32'h1a);
    rchk(smsp_pkg::ADDR_RX, 32'h5e);
    // second byte over unread data: dropped, then overwriting
    for (int k = 0; k < 2; k++) begin
      wr(smsp_pkg::ADDR_CTRL, 32'h0243 | (k << 8));
      xfer(8'h11, 8'h21);
      xfer(8'h12, 8'h22);
      rchk(smsp_pkg::ADDR_STATUS, 32'h3a);
      rchk(smsp_pkg::ADDR_RX, k ? 32'h22 : 32'h21);
      rchk(smsp_pkg::ADDR_STATUS, 32'h02);
    end
    // two queued bytes: one select window when continuous, two otherwise; loopback feeds the own bytes back
    for (int k = 0; k < 2; k++) begin
      wr(smsp_pkg::ADDR_CTRL, k ? 32'h0b43 : 32'h1b43);
      n0 = rises;
      wr(smsp_pkg::ADDR_TX, 32'h81);
      repeat (4) @(posedge clock_i);
      wr(smsp_pkg::ADDR_TX, 32'h82);
      wait_rise(k + 1);
      repeat (60) @(posedge clock_i);
      chk(rises - n0, k + 1);
      chk(p_rx, 8'h82);
      rchk(smsp_pkg::ADDR_RX, 32'h82);
    end
    // disable when idle clears the transmit flag; a disabled port stays still
    wr(smsp_pkg::ADDR_CTRL, 32'h0242);
    rchk(smsp_pkg::ADDR_STATUS, 32'h0);
    n0 = rises;
    wr(smsp_pkg::ADDR_TX, 32'h99);
    repeat (60) @(posedge clock_i);
    chk(rises - n0, 0);
    rchk(smsp_pkg::ADDR_STATUS, 32'h01);
    // slave: an external master clocks a byte in while the port shifts its own out
    wr(smsp_pkg::ADDR_CTRL, 32'h0401);
    wr(smsp_pkg::ADDR_TX, 32'hc3);
    chk(sclk_oe_n_o, 1'b1);
    m_ss_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      repeat (8) @(posedge clock_i);
      m_mosi <= SL_BYTE[b];
      repeat (8) @(posedge clock_i);
      sl_rx[b] = miso_w;
      m_sclk <= 1'b1;
      repeat (8) @(posedge clock_i);
      m_sclk <= 1'b0;
    end
    repeat (8) @(posedge clock_i);
    m_ss_n <= 1'b1;
    chk(sl_rx, 8'hc3);
    rchk(smsp_pkg::ADDR_RX, 32'h5a);
    summarize();
  end
endmodule : spi_master_slave_port_test
